// ===== adc_clock_source_select.sv
/*
 * Converter clock source selection: direct, DLL path or PLL, with output clock
 * and DLL reset control, reached over an Avalon-MM slave with waitrequest.
 * Assumes all inputs synchronous to mclk; analog clock paths obey the selects.
 */
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module adc_clock_source_select
(
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    input  wire logic [clk_sel_pkg::ADDR_W-1:0] address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [31:0]                  writedata,
    input  wire logic [3:0]                   byteenable,
    output logic      [31:0]                  readdata,
    output logic                              waitrequest,
    output clk_sel_pkg::core_src_t            coreClockSel,
    output logic                              coreClockGate,
    output logic                              dllEnable,
    output logic                              dllReset,
    output logic                              dutyCycleCorrection,
    output logic                              pllEnable,
    output logic                              pllRecalRun,
    output clk_sel_pkg::oclk_src_t            outputDataClockSel,
    output logic      [2:0]                   outputDataClockPhase
);
    import clk_sel_pkg::*;

    typedef struct packed
    {
        logic        waitReq;
        logic [31:0] rdata;
        logic        dutyEn;
        logic        dllEn;
        logic        delayLoopOutClockEnable;
        logic [2:0]  outClockPhaseDelay;
        logic        dllRstBit;
        logic        clkSource;
        logic        decEn;
        logic [2:0]  decimationOutPhaseDelay;
        logic        softAct;
        logic [3:0]  softCnt;
        logic        calBusy;
        logic        calDone;
        logic [9:0]  calCnt;
        logic        dllRstOut;
        logic        dutyOut;
        oclk_src_t   oclkSel;
        logic [2:0]  oclkPhase;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;
    clk_switch_if sw ();

    clock_switch_seq u_switch
    (
        .mclk   (mclk),
        .resetn (resetn),
        .sw     (sw.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic      wrTake;
    logic      rdTake;
    logic      wrLane;
    logic      softExit;
    logic      pllRecalTrigger;
    core_src_t wantSrc;
    logic      dllOutActive;

    assign wrTake = write && !st.waitReq;
    assign rdTake = read && st.waitReq;
    assign wrLane = wrTake && byteenable[0];
    assign softExit = st.softAct && (st.softCnt == 4'h0);
    assign pllRecalTrigger = wrLane && (address == regAddr(IDX_PLL_CAL)) && writedata[0];
    assign dllOutActive = st.dllEn && st.delayLoopOutClockEnable && (st.outClockPhaseDelay != 3'h0);

    always_comb
    begin
        wantSrc = SRC_DIRECT;
        if (st.clkSource)
        begin
            wantSrc = SRC_PLL;
        end
        else if (st.dllEn)
        begin
            wantSrc = SRC_DLL;
        end
    end

    assign sw.target = wantSrc;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        // one wait cycle, then the answer stands for the taking edge
        next_st.waitReq = !((read || write) && st.waitReq);
        if (rdTake)
        begin
            next_st.rdata = 32'h0;
            case (address)
                regAddr(IDX_SOFT_RESET):
                    next_st.rdata[0] = st.softAct;
                regAddr(IDX_DLL_CTRL):
                    next_st.rdata[6:0] = {st.dllRstBit, st.outClockPhaseDelay,
                        st.delayLoopOutClockEnable, st.dllEn, st.dutyEn};
                regAddr(IDX_CLK_SOURCE):
                    next_st.rdata[0] = st.clkSource;
                regAddr(IDX_DEC_PHASE):
                    next_st.rdata[3:0] = {st.decEn, st.decimationOutPhaseDelay};
                regAddr(IDX_STATUS):
                begin
                    next_st.rdata[ST_CAL_DONE] = st.calDone;
                    next_st.rdata[ST_CAL_BUSY] = st.calBusy;
                    next_st.rdata[ST_SW_BUSY]  = sw.busy;
                    next_st.rdata[ST_SRC_LSB +: 3] = sw.active;
                    next_st.rdata[ST_SOFT_BUSY] = st.softAct;
                end
                default:
                    next_st.rdata = 32'h0;
            endcase
        end

        // soft reset countdown
        if (st.softAct)
        begin
            next_st.softCnt = st.softCnt - 4'h1;
            if (softExit)
            begin
                next_st.softAct = 1'b0;
                if (st.dllEn)
                begin
                    next_st.dllRstBit = 1'b0;
                end
            end
        end

        if (wrLane)
        begin
            case (address)
                regAddr(IDX_SOFT_RESET):
                begin
                    if (writedata[0] && !st.softAct)
                    begin
                        next_st.softAct = 1'b1;
                        next_st.softCnt = 4'(SOFT_RESET_CYC - 1);
                    end
                end
                regAddr(IDX_DLL_CTRL):
                begin
                    next_st.dutyEn = writedata[DUTY_BIT];
                    next_st.dllEn = writedata[DLL_EN_BIT];
                    next_st.delayLoopOutClockEnable = writedata[DLL_OUT_BIT];
                    next_st.outClockPhaseDelay = writedata[PHASE_LSB +: 3];
                    next_st.dllRstBit = writedata[DLL_RESET_BIT];
                end
                regAddr(IDX_CLK_SOURCE):
                    next_st.clkSource = writedata[0];
                regAddr(IDX_DEC_PHASE):
                begin
                    next_st.decEn = writedata[DEC_EN_BIT];
                    next_st.decimationOutPhaseDelay = writedata[DEC_PHASE_LSB +: 3];
                end
                default:
                    next_st.decEn = st.decEn;
            endcase
        end

        if (pllRecalTrigger || softExit)
        begin
            next_st.calBusy = 1'b1;
            next_st.calDone = 1'b0;
            next_st.calCnt  = 10'(PLL_CAL_CYC - 1);
        end
        else if (st.calBusy)
        begin
            next_st.calCnt = st.calCnt - 10'h1;
            if (st.calCnt == 10'h0)
            begin
                next_st.calBusy = 1'b0;
                next_st.calDone = 1'b1;
            end
        end

        // dll held in reset during soft reset while the dll is enabled
        next_st.dllRstOut = next_st.dllRstBit || (next_st.softAct && next_st.dllEn);
        // correction only on the dll path
        next_st.dutyOut = next_st.dutyEn && next_st.dllEn && !next_st.clkSource;

        if (st.decEn)
        begin
            next_st.oclkSel   = OCLK_DECIM;
            next_st.oclkPhase = st.decimationOutPhaseDelay;
        end
        else if (dllOutActive && !st.clkSource)
        begin
            next_st.oclkSel   = OCLK_DLL;
            next_st.oclkPhase = st.outClockPhaseDelay;
        end
        else
        begin
            next_st.oclkSel   = OCLK_BUFFER;
            next_st.oclkPhase = 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.waitReq   <= 1'b1;
            st.dllRstBit <= DLL_CTRL_RST[DLL_RESET_BIT];
            st.dllRstOut <= 1'b1;
            st.oclkSel   <= OCLK_BUFFER;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign readdata             = st.rdata;
    assign waitrequest          = st.waitReq;
    assign coreClockSel         = sw.active;
    assign coreClockGate        = sw.gate;
    assign dllEnable            = st.dllEn;
    assign dllReset             = st.dllRstOut;
    // falling edge only in analog cell
    assign dutyCycleCorrection  = st.dutyOut;
    assign pllEnable            = st.clkSource;
    assign pllRecalRun          = st.calBusy;
    assign outputDataClockSel   = st.oclkSel;
    assign outputDataClockPhase = st.oclkPhase;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_bus_one_wait: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered after one wait cycle");

    a_bus_wait_back: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest stayed low two cycles");

    a_duty_dll_only: assert property (
        dutyCycleCorrection |-> dllEnable && !pllEnable)
        else $error("duty correction active off the dll path");

    // select held nine cycles: a switch in flight plus a fresh one end by then
    a_pll_core_src: assert property (
        $rose(pllEnable) ##1 pllEnable [*8]
        |-> ##[0:8] coreClockSel == SRC_PLL)
        else $error("pll mode without pll core clock");

    a_default_direct: assert property (
        (!pllEnable && !dllEnable) [*8]
        |-> ##[0:8] coreClockSel == SRC_DIRECT)
        else $error("core clock not direct with dll and pll off");

    a_dll_src_path: assert property (
        ($rose(dllEnable) && !pllEnable) ##1 (dllEnable && !pllEnable) [*8]
        |-> ##[0:8] coreClockSel == SRC_DLL)
        else $error("dll path not selected in time");

    a_dll_rst_held: assert property (
        dllReset && !(write && address == regAddr(IDX_DLL_CTRL)) && !st.softAct
        |=> dllReset)
        else $error("dll reset released without software");

    a_soft_dll_clear: assert property (
        softExit && st.dllEn && !wrLane |=> !st.dllRstBit)
        else $error("dll reset bit not cleared after soft reset");

    a_cal_after_soft: assert property (
        softExit |=> pllRecalRun && !st.calDone)
        else $error("pll calibration not started on soft reset exit");

    a_cal_complete: assert property (
        st.calBusy && st.calCnt == 10'h0 && !pllRecalTrigger && !softExit |=> st.calDone)
        else $error("pll calibration did not report completion");

    a_oclk_default: assert property (
        !st.decEn && !dllEnable |=> outputDataClockSel == OCLK_BUFFER
        && outputDataClockPhase == 3'h0)
        else $error("output clock not from buffer by default");

    a_decim_oclk: assert property (
        st.decEn |=> outputDataClockSel == OCLK_DECIM
        && outputDataClockPhase == $past(st.decimationOutPhaseDelay))
        else $error("decimation does not own the output clock");

    a_dll_oclk_phase: assert property (
        dllOutActive && !st.decEn && !st.clkSource |=> outputDataClockSel == OCLK_DLL
        && outputDataClockPhase == $past(st.outClockPhaseDelay))
        else $error("dll output clock phase not applied");

    a_soft_dll_hold: assert property (
        st.softAct && dllEnable |-> dllReset)
        else $error("dll not held in reset during soft reset");

    c_switch_pll: cover property ($rose(pllEnable) ##[1:8] coreClockSel == SRC_PLL);
    c_soft_exit: cover property (softExit && st.dllEn);
    c_cal_done: cover property ($rose(st.calDone));
    c_decim_clk: cover property (outputDataClockSel == OCLK_DECIM);
    c_dll_oclk: cover property (outputDataClockSel == OCLK_DLL);

endmodule
`default_nettype wire

// ===== clk_sel_pkg.sv
/*
 * Shared constants and types for the converter clock source selection block.
 * Assumes a single 50 MHz system clock and word-aligned register addressing.
 */
`default_nettype none
package clk_sel_pkg;

    localparam int CLK_PERIOD_NS   = 20;
    localparam int SWITCH_GATE_NS  = 60;
    localparam int SWITCH_GATE_CYC = (SWITCH_GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RESET_NS   = 200;
    localparam int SOFT_RESET_CYC  = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_CAL_NS      = 20000;
    localparam int PLL_CAL_CYC     = (PLL_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADDR_W = 10;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SOFT_RESET = 8'h00;
    localparam logic [7:0] IDX_DLL_CTRL   = 8'h52;
    localparam logic [7:0] IDX_CLK_SOURCE = 8'h53;
    localparam logic [7:0] IDX_DEC_PHASE  = 8'h64;
    localparam logic [7:0] IDX_PLL_CAL    = 8'h6b;
    localparam logic [7:0] IDX_STATUS     = 8'hd1;

    // dll control fields
    localparam int DUTY_BIT      = 0;
    localparam int DLL_EN_BIT    = 1;
    localparam int DLL_OUT_BIT   = 2;
    localparam int PHASE_LSB     = 3;
    localparam int DLL_RESET_BIT = 6;
    localparam logic [6:0] DLL_CTRL_RST = 7'h40;

    // decimation phase register fields
    localparam int DEC_PHASE_LSB = 0;
    localparam int DEC_EN_BIT    = 3;

    // status fields
    localparam int ST_CAL_DONE   = 0;
    localparam int ST_CAL_BUSY   = 1;
    localparam int ST_SW_BUSY    = 2;
    localparam int ST_SRC_LSB    = 3;
    localparam int ST_SOFT_BUSY  = 6;

    typedef enum logic [2:0]
    {
        SRC_DIRECT = 3'b001,
        SRC_DLL    = 3'b010,
        SRC_PLL    = 3'b100
    } core_src_t;

    typedef enum logic [2:0]
    {
        OCLK_BUFFER = 3'b001,
        OCLK_DLL    = 3'b010,
        OCLK_DECIM  = 3'b100
    } oclk_src_t;

    typedef enum logic [2:0]
    {
        SW_RUN    = 3'b001,
        SW_GATE   = 3'b010,
        SW_SETTLE = 3'b100
    } sw_state_t;

    function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage
`default_nettype wire

// ===== clk_switch_if.sv
/*
 * Link between the register side and the glitch-free clock switch sequencer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface clk_switch_if;
    import clk_sel_pkg::*;
    core_src_t target;
    core_src_t active;
    logic      gate;
    logic      busy;
    modport ctrl (output target, input active, input gate, input busy);
    modport seq  (input target, output active, output gate, output busy);
endinterface
`default_nettype wire

// ===== clock_switch_seq.sv
/*
 * Glitch-free core clock source switch: stop the clock, change source, settle, restart.
 * Assumes the target source is held stable by the controller between requests.
 */
`timescale 1ns/1ns
`default_nettype none
module clock_switch_seq
(
    input  wire logic mclk,
    input  wire logic resetn,
    clk_switch_if.seq sw
);
    import clk_sel_pkg::*;

    typedef struct packed
    {
        sw_state_t state;
        logic [3:0] cnt;
        core_src_t active;
        logic      gate;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;

    assign sw.active = st.active;
    assign sw.gate   = st.gate;
    assign sw.busy   = (st.state != SW_RUN);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        case (st.state)
            SW_RUN:
            begin
                if (sw.target != st.active)
                begin
                    next_st.gate  = 1'b0;
                    next_st.cnt   = 4'(SWITCH_GATE_CYC - 1);
                    next_st.state = SW_GATE;
                end
            end
            SW_GATE:
            begin
                if (st.cnt == 4'h0)
                begin
                    next_st.active = sw.target;
                    next_st.cnt    = 4'(SWITCH_GATE_CYC - 1);
                    next_st.state  = SW_SETTLE;
                end
                else
                begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            SW_SETTLE:
            begin
                if (st.cnt == 4'h0)
                begin
                    next_st.gate  = 1'b1;
                    next_st.state = SW_RUN;
                end
                else
                begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            default:
            begin
                next_st.state = SW_RUN;
                next_st.gate  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '{state: SW_RUN, cnt: 4'h0, active: SRC_DIRECT, gate: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_src_gated_change: assert property (
        (st.active != $past(st.active)) |-> !st.gate && !$past(st.gate))
        else $error("core source changed while clock gate open");

    a_gate_low_time: assert property (
        $fell(st.gate) |-> !st.gate [*4])
        else $error("clock gate reopened too early");

endmodule
`default_nettype wire

// ===== host_bus_model.sv
/*
 * Register-programming host: an Avalon-MM master with transfer tasks.
 * Assumes a slave that answers with waitrequest low for one cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
(
    input  wire logic                        mclk,
    input  wire logic                        waitrequest,
    input  wire logic [31:0]                 readdata,
    output var  logic [clk_sel_pkg::ADDR_W-1:0] address,
    output var  logic                        read,
    output var  logic                        write,
    output var  logic [31:0]                 writedata,
    output var  logic [3:0]                  byteenable
);
    import clk_sel_pkg::*;
    // reference within 5 to 250 MHz
    // PLL used for 80 to 250 MHz sampling only
    localparam int REF_CLK_MHZ = 100;
    initial
    begin
        address    = '0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = '0;
        byteenable = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one transfer; entered right after a rising edge
    task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] d,
                        output logic [31:0] q);
        address    <= {idx, 2'b00};
        read       <= rd;
        write      <= !rd;
        writedata  <= {24'h0, d};
        byteenable <= 4'h1;
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // pulse the loop reset after a clock change
    task automatic freqChange(input logic [7:0] ctrl);
        logic [31:0] q;
        xfer(1'b0, IDX_DLL_CTRL, ctrl | 8'h40, q);
        xfer(1'b0, IDX_DLL_CTRL, ctrl & 8'hbf, q);
    endtask
    // duty correction is enabled by the bench only to exercise it
endmodule
`default_nettype wire

// ===== adc_clock_source_select_tb_top.sv
/*
 * Self-checking bench for the converter clock source selection block.
 * Assumes the host model drives the register bus; one 50 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_clock_source_select_tb_top;
    import clk_sel_pkg::*;
    logic                mclk;
    logic                resetn;
    logic [ADDR_W-1:0]   address;
    logic                read;
    logic                write;
    logic [31:0]         writedata;
    logic [3:0]          byteenable;
    logic [31:0]         readdata;
    logic                waitrequest;
    core_src_t           coreClockSel;
    logic                coreClockGate;
    logic                dllEnable;
    logic                dllReset;
    logic                dutyCycleCorrection;
    logic                pllEnable;
    logic                pllRecalRun;
    oclk_src_t           outputDataClockSel;
    logic [2:0]          outputDataClockPhase;
    logic [31:0]         q;
    int                  errorCnt;
    int                  totalChecks;
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        errorCnt = 0;
        totalChecks = 0;
    end
    always #10 mclk = ~mclk;
    adc_clock_source_select DUT (.mclk(mclk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .coreClockSel(coreClockSel),
        .coreClockGate(coreClockGate), .dllEnable(dllEnable), .dllReset(dllReset),
        .dutyCycleCorrection(dutyCycleCorrection), .pllEnable(pllEnable),
        .pllRecalRun(pllRecalRun), .outputDataClockSel(outputDataClockSel),
        .outputDataClockPhase(outputDataClockPhase));
    host_bus_model host (.mclk(mclk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // wait for the core clock to stop and restart, then check the new source
    task automatic switchTo(input core_src_t oldSrc, input core_src_t newSrc);
        int n;
        n = 0;
        while (coreClockGate !== 1'b0 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        chk("gate low", 32'h0, coreClockGate);
        chk("sel at stop", oldSrc, coreClockSel);
        n = 0;
        while (coreClockGate !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        chk("gate high", 32'h1, coreClockGate);
        chk("sel at restart", newSrc, coreClockSel);
    endtask
    task automatic pollStatus(input int b, input logic v, input int maxN);
        int n;
        n = 0;
        do
        begin
            host.xfer(1'b1, IDX_STATUS, 8'h0, q);
            n++;
        end
        while (q[b] !== v && n < maxN);
        chk("status bit", v, q[b]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("core sel", SRC_DIRECT, coreClockSel);
        chk("dll reset", 32'h1, dllReset);
        chk("oclk sel", OCLK_BUFFER, outputDataClockSel);
        chk("pll", 32'h0, {pllEnable, dllEnable});
        host.xfer(1'b1, IDX_DLL_CTRL, 8'h0, q);
        chk("dll ctrl", 32'h40, q);
        host.xfer(1'b1, 8'h10, 8'h0, q);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
        host.xfer(1'b0, IDX_DLL_CTRL, 8'h03, q);
        chk("dll on", 32'h1, dllEnable);
        chk("duty", 32'h1, dutyCycleCorrection);
        chk("dll out", 32'h0, dllReset);
        switchTo(SRC_DIRECT, SRC_DLL);
        host.xfer(1'b0, IDX_CLK_SOURCE, 8'h01, q);
        chk("pll on", 32'h1, pllEnable);
        chk("duty pll", 32'h0, dutyCycleCorrection);
        switchTo(SRC_DLL, SRC_PLL);
        host.xfer(1'b0, IDX_CLK_SOURCE, 8'h00, q);
        switchTo(SRC_PLL, SRC_DLL);
        $display("test source switch done");
        host.freqChange(8'h2e);
        chk("oclk dll", OCLK_DLL, outputDataClockSel);
        chk("oclk phase", 32'h5, outputDataClockPhase);
        host.xfer(1'b0, IDX_DEC_PHASE, 8'h0b, q);
        @(posedge mclk);
        chk("oclk decim", OCLK_DECIM, outputDataClockSel);
        chk("dec phase", 32'h3, outputDataClockPhase);
        $display("test output clock done");
        host.xfer(1'b0, IDX_SOFT_RESET, 8'h01, q);
        chk("dll reset soft", 32'h1, dllReset);
        pollStatus(ST_SOFT_BUSY, 1'b0, 20);
        host.xfer(1'b1, IDX_DLL_CTRL, 8'h0, q);
        chk("dll reset bit", 32'h0, q[DLL_RESET_BIT]);
        chk("dll reset out", 32'h0, dllReset);
        chk("cal run", 32'h1, pllRecalRun);
        pollStatus(ST_CAL_DONE, 1'b1, 700);
        chk("cal stop", 32'h0, pllRecalRun);
        host.xfer(1'b0, IDX_PLL_CAL, 8'h01, q);
        chk("trig run", 32'h1, pllRecalRun);
        pollStatus(ST_CAL_BUSY, 1'b0, 700);
        host.xfer(1'b0, IDX_DLL_CTRL, 8'h6e, q);
        chk("dll reset set", 32'h1, dllReset);
        host.xfer(1'b0, IDX_SOFT_RESET, 8'h01, q);
        pollStatus(ST_SOFT_BUSY, 1'b0, 20);
        host.xfer(1'b1, IDX_DLL_CTRL, 8'h0, q);
        chk("dll reset auto", 32'h0, q[DLL_RESET_BIT]);
        chk("dll reset auto out", 32'h0, dllReset);
        $display("test soft reset done");
        print_verdict();
    end
    initial
    begin
        repeat (8000) @(posedge mclk);
        errorCnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
